// *** shared/drvod_pkg.sv ***
// Package with object indices, fixed entries and reset values of the drive object dictionary
package drvod_pkg;
  localparam logic [15:0] IDX_DEV_TYPE   = 16'h1000;
  localparam logic [15:0] IDX_FW_VER     = 16'h100a;
  localparam logic [15:0] IDX_IDENTITY   = 16'h1018;
  localparam logic [15:0] IDX_RX_MAP     = 16'h1600;
  localparam logic [15:0] IDX_TX_MAP     = 16'h1a00;
  localparam logic [15:0] IDX_SM_TYPES   = 16'h1c00;
  localparam logic [15:0] IDX_MBX_OUT    = 16'h1c10;
  localparam logic [15:0] IDX_MBX_IN     = 16'h1c11;
  localparam logic [15:0] IDX_OUT_ASSIGN = 16'h1c12;
  localparam logic [15:0] IDX_IN_ASSIGN  = 16'h1c13;
  localparam logic [15:0] IDX_SCRATCH    = 16'h2000;
  localparam logic [15:0] IDX_GOAL       = 16'h2001;
  localparam logic [15:0] IDX_CURRENT    = 16'h2003;
  localparam logic [15:0] IDX_OFFSET     = 16'h2004;
  localparam logic [15:0] IDX_FOLLOW_LIM = 16'h2005;

  localparam logic [31:0] DEV_TYPE_VAL   = 32'h0000_0000;
  localparam logic [7:0]  IDENT_COUNT    = 8'h04;
  localparam logic [7:0]  RX_MAP_COUNT   = 8'h02;
  localparam logic [31:0] RX_MAP_ENTRY1  = 32'h2024_0010;
  localparam logic [31:0] RX_MAP_ENTRY2  = 32'h2001_0020;
  localparam logic [7:0]  TX_MAP_COUNT   = 8'h03;
  localparam logic [31:0] TX_MAP_ENTRY1  = 32'h2025_0010;
  localparam logic [31:0] TX_MAP_ENTRY2  = 32'h2030_0010;
  localparam logic [31:0] TX_MAP_ENTRY3  = 32'h2003_0020;
  localparam logic [7:0]  SM_COUNT       = 8'h04;
  localparam logic [7:0]  MBX_ASSIGN_CNT = 8'h00;
  localparam logic [7:0]  PD_ASSIGN_CNT  = 8'h01;
  localparam logic [7:0]  SCRATCH_COUNT  = 8'h0a;
  localparam int          SCRATCH_NUM    = 10;

  localparam logic [7:0]  SUB_0          = 8'h00;
  localparam logic [7:0]  SUB_1          = 8'h01;
  localparam logic [7:0]  SUB_2          = 8'h02;
  localparam logic [7:0]  SUB_3          = 8'h03;
  localparam logic [7:0]  SUB_4          = 8'h04;

  localparam logic [15:0] SCRATCH_RST    = 16'h0000;
  localparam logic [31:0] POS_RST        = 32'h0000_0000;
  localparam logic [15:0] FOLLOW_LIM_RST = 16'h0000;
  localparam logic [15:0] CTRL_WORD_RST  = 16'h0000;
  localparam int          FOLLOW_ERR_BIT = 8;
endpackage : drvod_pkg

// *** core/drvod_dictionary.sv ***
// Object dictionary of the positioning drive: mailbox access, fixed process data, positions
`timescale 1ns/1ps
module drvod_dictionary #(
  parameter int          FW_LEN      = 8,
  parameter logic [63:0] FW_STRING   = 64'h4452_5646_575f_3031, // "DRVFW_01", arbitrary
  parameter logic [31:0] VENDOR_CODE = 32'h0000_0a5a,            // Arbitrary value
  parameter logic [31:0] PRODUCT_CODE= 32'h0000_1234,            // Arbitrary value
  parameter logic [31:0] REVISION    = 32'h0000_0001,            // Arbitrary value
  parameter logic [31:0] SERIAL_NUM  = 32'h0000_0000             // Arbitrary value
) (
  input  wire logic        i_sys_clk,        // System clock, 250 MHz
  input  wire logic        i_resetn,         // Asynchronous reset, active low
  input  wire logic        i_sdo_req,        // Mailbox request strobe
  input  wire logic        i_sdo_wr,         // Request is a download (write)
  input  wire logic [15:0] i_sdo_index,      // Object index
  input  wire logic [7:0]  i_sdo_sub,        // Object sub-index
  input  wire logic [31:0] i_sdo_wdata,      // Write data, right aligned
  output logic             o_sdo_done,       // Answer strobe
  output logic             o_sdo_abort,      // Answer is an abort
  output logic [31:0]      o_sdo_rdata,      // Read data, right aligned
  input  wire logic        i_rxpdo_valid,    // Receive process data strobe
  input  wire logic [15:0] i_rxpdo_ctrl,     // Mapped control word
  input  wire logic [31:0] i_rxpdo_goal,     // Mapped goal position
  output logic [15:0]      o_control_word,   // Latched control word
  output logic [31:0]      o_cmd_position,   // Goal in raw drive frame
  input  wire logic [31:0] i_raw_position,   // Position from the motion core
  input  wire logic        i_axis_moving,    // Axis not at standstill
  input  wire logic [15:0] i_status_word,    // Status word from the motion core
  input  wire logic [15:0] i_aux_word,       // Second transmitted word
  output logic [15:0]      o_txpdo_status,   // Transmitted status word
  output logic [15:0]      o_txpdo_aux,      // Transmitted second word
  output logic [31:0]      o_txpdo_position, // Transmitted current position
  output logic             o_follow_err      // Following-error status bit
);
  import drvod_pkg::*;

  logic [15:0] scratch_q [SCRATCH_NUM];
  logic [31:0] goal_q;
  logic [31:0] home_q;
  logic [31:0] offset_q;
  logic [15:0] follow_lim_q;
  logic [15:0] ctrl_q;
  logic [31:0] current_pos;
  logic [31:0] rd_d;
  logic        rd_ok_d;
  logic        wr_ok_d;
  logic        wr_go;
  logic        sub0;
  logic        scratch_sel;
  logic [3:0]  scratch_idx;
  logic [31:0] deviation;
  logic [31:0] dev_abs;

  assign sub0        = (i_sdo_sub == SUB_0);
  assign scratch_sel = (i_sdo_sub >= SUB_1) && (i_sdo_sub <= SCRATCH_COUNT);
  assign scratch_idx = 4'(i_sdo_sub - SUB_1);

  // Offset and referencing base together map the raw frame onto the user frame
  assign current_pos = i_raw_position + home_q + offset_q;

  // Read side of every entry; unknown entries abort
  always_comb begin
    int unsigned bsel;
    bsel    = 0;
    rd_d    = 32'h0000_0000;
    rd_ok_d = 1'b0;
    case (i_sdo_index)
      IDX_DEV_TYPE: begin
        rd_ok_d = sub0;
        rd_d    = DEV_TYPE_VAL;
      end
      IDX_FW_VER: begin
        // One character per sub-index, first character at sub-index 0
        if (32'(i_sdo_sub) < FW_LEN) begin
          bsel    = FW_LEN - 1 - 32'(i_sdo_sub);
          rd_ok_d = 1'b1;
          rd_d    = {24'h00_0000, FW_STRING[8*bsel +: 8]};
        end
      end
      IDX_IDENTITY: begin
        rd_ok_d = 1'b1;
        case (i_sdo_sub)
          SUB_0:   rd_d = {24'h00_0000, IDENT_COUNT};
          SUB_1:   rd_d = VENDOR_CODE;
          SUB_2:   rd_d = PRODUCT_CODE;
          SUB_3:   rd_d = REVISION;
          SUB_4:   rd_d = SERIAL_NUM;
          default: rd_ok_d = 1'b0;
        endcase
      end
      IDX_RX_MAP: begin
        rd_ok_d = 1'b1;
        case (i_sdo_sub)
          SUB_0:   rd_d = {24'h00_0000, RX_MAP_COUNT};
          SUB_1:   rd_d = RX_MAP_ENTRY1;
          SUB_2:   rd_d = RX_MAP_ENTRY2;
          default: rd_ok_d = 1'b0;
        endcase
      end
      IDX_TX_MAP: begin
        rd_ok_d = 1'b1;
        case (i_sdo_sub)
          SUB_0:   rd_d = {24'h00_0000, TX_MAP_COUNT};
          SUB_1:   rd_d = TX_MAP_ENTRY1;
          SUB_2:   rd_d = TX_MAP_ENTRY2;
          SUB_3:   rd_d = TX_MAP_ENTRY3;
          default: rd_ok_d = 1'b0;
        endcase
      end
      IDX_SM_TYPES: begin
        // Type code of manager n equals its sub-index n+1
        rd_ok_d = (i_sdo_sub <= SM_COUNT);
        rd_d    = sub0 ? {24'h00_0000, SM_COUNT} : {24'h00_0000, i_sdo_sub};
      end
      IDX_MBX_OUT, IDX_MBX_IN: begin
        rd_ok_d = sub0;
        rd_d    = {24'h00_0000, MBX_ASSIGN_CNT};
      end
      IDX_OUT_ASSIGN: begin
        rd_ok_d = sub0 || (i_sdo_sub == SUB_1);
        rd_d    = sub0 ? {24'h00_0000, PD_ASSIGN_CNT} : {16'h0000, IDX_RX_MAP};
      end
      IDX_IN_ASSIGN: begin
        rd_ok_d = sub0 || (i_sdo_sub == SUB_1);
        rd_d    = sub0 ? {24'h00_0000, PD_ASSIGN_CNT} : {16'h0000, IDX_TX_MAP};
      end
      IDX_SCRATCH: begin
        rd_ok_d = sub0 || scratch_sel;
        if (sub0) begin
          rd_d = {24'h00_0000, SCRATCH_COUNT};
        end else if (scratch_sel) begin
          rd_d = {16'h0000, scratch_q[scratch_idx]};
        end
      end
      IDX_GOAL: begin
        rd_ok_d = sub0;
        rd_d    = goal_q;
      end
      IDX_CURRENT: begin
        rd_ok_d = sub0;
        rd_d    = current_pos;
      end
      IDX_OFFSET: begin
        rd_ok_d = sub0;
        rd_d    = offset_q;
      end
      IDX_FOLLOW_LIM: begin
        rd_ok_d = sub0;
        rd_d    = {16'h0000, follow_lim_q};
      end
      default: begin
        rd_ok_d = 1'b0;
      end
    endcase
  end

  // Write permission: only writable entries, position frame only at standstill
  always_comb begin
    case (i_sdo_index)
      IDX_SCRATCH:    wr_ok_d = scratch_sel;
      IDX_GOAL:       wr_ok_d = sub0;
      IDX_CURRENT:    wr_ok_d = sub0 && !i_axis_moving;
      IDX_OFFSET:     wr_ok_d = sub0 && !i_axis_moving;
      IDX_FOLLOW_LIM: wr_ok_d = sub0;
      default:        wr_ok_d = 1'b0;
    endcase
  end

  assign wr_go = i_sdo_req && i_sdo_wr && wr_ok_d;

  // Answer one cycle after the request
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sdo_done  <= 1'b0;
      o_sdo_abort <= 1'b0;
      o_sdo_rdata <= 32'h0000_0000;
    end else begin
      o_sdo_done  <= i_sdo_req;
      o_sdo_abort <= i_sdo_req && (i_sdo_wr ? !wr_ok_d : !rd_ok_d);
      o_sdo_rdata <= (i_sdo_req && !i_sdo_wr && rd_ok_d) ? rd_d : 32'h0000_0000;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < SCRATCH_NUM; i++) begin
        scratch_q[i] <= SCRATCH_RST;
      end
    end else if (wr_go && (i_sdo_index == IDX_SCRATCH)) begin
      scratch_q[scratch_idx] <= i_sdo_wdata[15:0];
    end
  end

  // Mailbox write takes priority over process data landing in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      goal_q <= POS_RST;
    end else if (wr_go && (i_sdo_index == IDX_GOAL)) begin
      goal_q <= i_sdo_wdata;
    end else if (i_rxpdo_valid) begin
      goal_q <= i_rxpdo_goal;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_q <= CTRL_WORD_RST;
    end else if (i_rxpdo_valid) begin
      ctrl_q <= i_rxpdo_ctrl;
    end
  end

  // Referencing shifts the frame so the current position reads the written value
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      home_q <= POS_RST;
    end else if (wr_go && (i_sdo_index == IDX_CURRENT)) begin
      home_q <= i_sdo_wdata - i_raw_position - offset_q;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      offset_q <= POS_RST;
    end else if (wr_go && (i_sdo_index == IDX_OFFSET)) begin
      offset_q <= i_sdo_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      follow_lim_q <= FOLLOW_LIM_RST;
    end else if (wr_go && (i_sdo_index == IDX_FOLLOW_LIM)) begin
      follow_lim_q <= i_sdo_wdata[15:0];
    end
  end

  // Deviation measured in the user frame; limit is unsigned
  assign deviation = goal_q - current_pos;
  assign dev_abs   = deviation[31] ? (32'h0000_0000 - deviation) : deviation;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_follow_err <= 1'b0;
    end else begin
      o_follow_err <= (dev_abs > {16'h0000, follow_lim_q});
    end
  end

  // Units pass unscaled; scaling to 1/100 mm lives in the motion core
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_control_word   <= CTRL_WORD_RST;
      o_cmd_position   <= POS_RST;
      o_txpdo_status   <= 16'h0000;
      o_txpdo_aux      <= 16'h0000;
      o_txpdo_position <= POS_RST;
    end else begin
      o_control_word   <= ctrl_q;
      o_cmd_position   <= goal_q - home_q - offset_q;
      o_txpdo_status   <= i_status_word | (16'(o_follow_err) << FOLLOW_ERR_BIT);
      o_txpdo_aux      <= i_aux_word;
      o_txpdo_position <= current_pos;
    end
  end
endmodule : drvod_dictionary

// *** dv/drvod_dictionary_properties.sv ***
// Concurrent checks on the dictionary mailbox answers and status outputs
`timescale 1ns/1ps
module drvod_dictionary_properties
  import drvod_pkg::*;
(
  input wire logic        i_sys_clk,     // Clock
  input wire logic        i_resetn,      // Reset, active low
  input wire logic        i_sdo_req,     // Request
  input wire logic        i_sdo_wr,      // Write
  input wire logic [15:0] i_sdo_index,   // Index
  input wire logic [7:0]  i_sdo_sub,     // Sub-index
  input wire logic        i_axis_moving, // Moving
  input wire logic        o_sdo_done,    // Answer
  input wire logic        o_sdo_abort,   // Abort
  input wire logic [31:0] o_sdo_rdata,   // Read data
  input wire logic        o_follow_err,  // Following error
  input wire logic [15:0] o_txpdo_status // Status word
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  logic rd;
  assign rd = i_sdo_req && !i_sdo_wr;
  a_done_one_cycle: assert property (i_sdo_req |=> o_sdo_done)
    else $error("mailbox answer missing");
  a_no_idle_answer: assert property (!i_sdo_req |=> !o_sdo_done && o_sdo_rdata == 32'h0)
    else $error("answer without request");
  a_abort_paired: assert property (o_sdo_abort |-> o_sdo_done)
    else $error("abort without answer");
  a_devtype_zero: assert property (rd && i_sdo_index == IDX_DEV_TYPE |=>
    !o_sdo_abort && o_sdo_rdata == DEV_TYPE_VAL) else $error("device type not zero");
  a_ident_count: assert property (rd && i_sdo_index == IDX_IDENTITY && i_sdo_sub == SUB_0
    |=> o_sdo_rdata == {24'h0, IDENT_COUNT}) else $error("identity count wrong");
  a_rx_map_entry: assert property (rd && i_sdo_index == IDX_RX_MAP && i_sdo_sub == SUB_2
    |=> o_sdo_rdata == RX_MAP_ENTRY2) else $error("receive mapping wrong");
  a_tx_map_entry: assert property (rd && i_sdo_index == IDX_TX_MAP && i_sdo_sub == SUB_3
    |=> o_sdo_rdata == TX_MAP_ENTRY3) else $error("transmit mapping wrong");
  a_ro_write_abort: assert property (i_sdo_req && i_sdo_wr && i_sdo_index[15:12] == 4'h1
    |=> o_sdo_abort) else $error("read-only write accepted");
  a_moving_refused: assert property (i_sdo_req && i_sdo_wr && i_axis_moving &&
    (i_sdo_index == IDX_CURRENT || i_sdo_index == IDX_OFFSET) |=> o_sdo_abort)
    else $error("write during motion accepted");
  a_follow_status: assert property (o_follow_err |=> o_txpdo_status[8])
    else $error("status lacks following error");
endmodule : drvod_dictionary_properties

bind drvod_dictionary drvod_dictionary_properties i_props (.i_sys_clk(i_sys_clk),
  .i_resetn(i_resetn), .i_sdo_req(i_sdo_req), .i_sdo_wr(i_sdo_wr), .i_sdo_sub(i_sdo_sub),
  .i_sdo_index(i_sdo_index), .i_axis_moving(i_axis_moving), .o_sdo_done(o_sdo_done),
  .o_sdo_abort(o_sdo_abort), .o_sdo_rdata(o_sdo_rdata), .o_follow_err(o_follow_err),
  .o_txpdo_status(o_txpdo_status));

// *** dv/drvod_master.sv ***
// Bus master model that issues single mailbox requests
`timescale 1ns/1ps
module drvod_master (
  input  wire logic        i_sys_clk,   // Clock
  input  wire logic        i_sdo_done,  // Answer strobe
  input  wire logic        i_sdo_abort, // Abort flag
  input  wire logic [31:0] i_sdo_rdata, // Read data
  output logic             o_sdo_req,   // Request strobe
  output logic             o_sdo_wr,    // Write
  output logic [15:0]      o_sdo_index, // Index
  output logic [7:0]       o_sdo_sub,   // Sub-index
  output logic [31:0]      o_sdo_wdata  // Write data
);
  initial begin
    o_sdo_req = 1'b0;
    o_sdo_wr = 1'b0;
    o_sdo_index = 16'h0;
    o_sdo_sub = 8'h0;
    o_sdo_wdata = 32'h0;
  end
  // Goal writes go by mailbox as in pre-operational state; the control word comes by process data only
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                      input logic [31:0] wd, output logic [31:0] rd, output logic ab,
                      output logic dn);
    @(negedge i_sys_clk);
    o_sdo_req = 1'b1;
    o_sdo_wr = w;
    o_sdo_index = idx;
    o_sdo_sub = sub;
    o_sdo_wdata = wd;
    @(negedge i_sys_clk);
    o_sdo_req = 1'b0;
    // Stale data must not look valid once the request is gone
    o_sdo_wdata = ~wd;
    dn = i_sdo_done;
    ab = i_sdo_abort;
    rd = i_sdo_rdata;
  endtask : xfer
endmodule : drvod_master

// *** dv/testbench.sv ***
// Self-checking bench for the drive object dictionary
`timescale 1ns/1ps
module testbench;
  import drvod_pkg::*;
  logic i_sys_clk = 1'b0, i_resetn = 1'b0, i_rxpdo_valid = 1'b0, i_axis_moving = 1'b0;
  logic i_sdo_req, i_sdo_wr, o_sdo_done, o_sdo_abort, o_follow_err;
  logic [7:0]  i_sdo_sub;
  logic [15:0] i_sdo_index, i_rxpdo_ctrl = 16'h0, i_status_word = 16'h0, i_aux_word = 16'h0;
  logic [15:0] o_control_word, o_txpdo_status, o_txpdo_aux;
  logic [31:0] i_sdo_wdata, o_sdo_rdata, i_rxpdo_goal = 32'h0, i_raw_position = 32'h100;
  logic [31:0] o_cmd_position, o_txpdo_position;
  int errors = 0;
  int comparisons = 0;
  // Identity values are arbitrary
  drvod_dictionary #(.VENDOR_CODE(32'h5a01), .PRODUCT_CODE(32'h7e02), .REVISION(32'h3),
    .SERIAL_NUM(32'h42)) i_dut (.*);
  drvod_master i_master (.i_sys_clk(i_sys_clk), .i_sdo_done(o_sdo_done),
    .i_sdo_abort(o_sdo_abort), .i_sdo_rdata(o_sdo_rdata), .o_sdo_req(i_sdo_req),
    .o_sdo_wr(i_sdo_wr), .o_sdo_index(i_sdo_index), .o_sdo_sub(i_sdo_sub),
    .o_sdo_wdata(i_sdo_wdata));
  always #2 i_sys_clk = ~i_sys_clk;
  localparam logic [55:0] FIX [26] = '{{16'h1000, 8'h0, 32'h0}, {16'h100a, 8'h0, 32'h44},
    {16'h1018, 8'h0, 32'h4}, {16'h1018, 8'h1, 32'h5a01}, {16'h1018, 8'h2, 32'h7e02},
    {16'h1018, 8'h3, 32'h3}, {16'h1018, 8'h4, 32'h42}, {16'h1600, 8'h0, 32'h2},
    {16'h1600, 8'h1, 32'h2024_0010}, {16'h1600, 8'h2, 32'h2001_0020}, {16'h1a00, 8'h0, 32'h3},
    {16'h1a00, 8'h1, 32'h2025_0010}, {16'h1a00, 8'h2, 32'h2030_0010},
    {16'h1a00, 8'h3, 32'h2003_0020}, {16'h1c00, 8'h0, 32'h4}, {16'h1c00, 8'h1, 32'h1},
    {16'h1c00, 8'h2, 32'h2}, {16'h1c00, 8'h3, 32'h3}, {16'h1c00, 8'h4, 32'h4},
    {16'h1c10, 8'h0, 32'h0}, {16'h1c11, 8'h0, 32'h0}, {16'h1c12, 8'h0, 32'h1},
    {16'h1c12, 8'h1, 32'h1600}, {16'h1c13, 8'h0, 32'h1}, {16'h1c13, 8'h1, 32'h1a00},
    {16'h2000, 8'h0, 32'ha}};
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask : chk
  task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [31:0] wd, input logic [31:0] exp, input logic ab);
    logic [31:0] rd;
    logic        a;
    logic        d;
    i_master.xfer(w, idx, sub, wd, rd, a, d);
    chk("done", 32'h1, {31'h0, d});
    chk("abort", {31'h0, ab}, {31'h0, a});
    chk("rdata", (w || ab) ? 32'h0 : exp, rd);
  endtask : acc
  task automatic t_fixed;
    foreach (FIX[i]) begin
      acc(1'b1, FIX[i][55:40], FIX[i][39:32], ~FIX[i][31:0], 32'h0, 1'b1);
      acc(1'b0, FIX[i][55:40], FIX[i][39:32], 32'h0, FIX[i][31:0], 1'b0);
    end
    acc(1'b0, 16'h3000, 8'h0, 32'h0, 32'h0, 1'b1);
  endtask : t_fixed
  task automatic t_scratch;
    for (int i = 1; i <= 10; i++) begin
      acc(1'b0, IDX_SCRATCH, 8'(i), 32'h0, 32'h0, 1'b0);
      acc(1'b1, IDX_SCRATCH, 8'(i), 32'ha500 + i, 32'h0, 1'b0);
    end
    for (int i = 1; i <= 10; i++) acc(1'b0, IDX_SCRATCH, 8'(i), 0, 32'ha500 + i, 1'b0);
    acc(1'b0, IDX_SCRATCH, 8'hb, 32'h0, 32'h0, 1'b1);
  endtask : t_scratch
  task automatic t_goal;
    acc(1'b0, IDX_GOAL, 8'h0, 32'h0, 32'h0, 1'b0);
    acc(1'b1, IDX_GOAL, 8'h0, 32'hffff_ff9c, 32'h0, 1'b0);
    acc(1'b0, IDX_GOAL, 8'h0, 32'h0, 32'hffff_ff9c, 1'b0);
    @(negedge i_sys_clk);
    i_rxpdo_valid = 1'b1;
    i_rxpdo_ctrl = 16'h0014;
    i_rxpdo_goal = 32'h1388;
    i_aux_word = 16'h5a5a;
    @(negedge i_sys_clk);
    i_rxpdo_valid = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    chk("ctrl", 32'h14, {16'h0, o_control_word});
    chk("cmd", 32'h1388, o_cmd_position);
    chk("aux", 32'h5a5a, {16'h0, o_txpdo_aux});
    acc(1'b0, IDX_GOAL, 8'h0, 32'h0, 32'h1388, 1'b0);
  endtask : t_goal
  task automatic t_refer;
    i_axis_moving = 1'b1;
    acc(1'b1, IDX_CURRENT, 8'h0, 32'h50, 32'h0, 1'b1);
    acc(1'b1, IDX_OFFSET, 8'h0, 32'h50, 32'h0, 1'b1);
    acc(1'b0, IDX_CURRENT, 8'h0, 32'h0, 32'h100, 1'b0);
    i_axis_moving = 1'b0;
    acc(1'b1, IDX_CURRENT, 8'h0, 32'h2000, 32'h0, 1'b0);
    i_raw_position = 32'h110;
    acc(1'b0, IDX_CURRENT, 8'h0, 32'h0, 32'h2010, 1'b0);
    acc(1'b1, IDX_OFFSET, 8'h0, 32'h30, 32'h0, 1'b0);
    acc(1'b0, IDX_OFFSET, 8'h0, 32'h0, 32'h30, 1'b0);
    acc(1'b0, IDX_CURRENT, 8'h0, 32'h0, 32'h2040, 1'b0);
    chk("cmd", 32'hffff_f458, o_cmd_position);
    chk("txpos", 32'h2040, o_txpdo_position);
  endtask : t_refer
  task automatic t_follow;
    i_status_word = 16'h0003;
    acc(1'b1, IDX_FOLLOW_LIM, 8'h0, 32'h0cb8, 32'h0, 1'b0);
    repeat (2) @(negedge i_sys_clk);
    chk("follow", 32'h0, {31'h0, o_follow_err});
    chk("status", 32'h3, {16'h0, o_txpdo_status});
    acc(1'b1, IDX_FOLLOW_LIM, 8'h0, 32'h0cb7, 32'h0, 1'b0);
    repeat (2) @(negedge i_sys_clk);
    chk("follow", 32'h1, {31'h0, o_follow_err});
    chk("status", 32'h103, {16'h0, o_txpdo_status});
  endtask : t_follow
  task automatic wrap_up;
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #40000;
    errors++;
    wrap_up();
  end
  initial begin
    repeat (3) @(negedge i_sys_clk);
    i_resetn = 1'b1;
    t_fixed();
    t_scratch();
    t_goal();
    t_refer();
    t_follow();
    wrap_up();
  end
endmodule : testbench
